// *** rtl/octal_adc_defines.svh ***
// Function
// - ten-bit word, line 0 least significant
// - eight channel ports, same bit order
// - ten stages, each resolves one bit
// - one stage per half sample clock
// - word appears 6.5 sample clocks later
// - one common clock samples every channel
// - all eight ports update together
// - active-low enable drives or floats outputs
`ifndef OCTAL_ADC_DEFINES_SVH
`define OCTAL_ADC_DEFINES_SVH

`define ADC_WORD_BITS        10
`define ADC_CHANNELS         8
`define ADC_STAGES           10
// correction ticks, in half sample clocks, ahead of the output latch inside the buffer
`define ADC_CORR_TICKS       2
// one clock tick is one half of the sample clock
`define ADC_TICKS_PER_SAMPLE 2
// total latency in ticks: stages + correction + buffer output latch = 13 = 6.5 samples
`define ADC_LATENCY_TICKS    13
`define ADC_CLOCK_PERIOD_PS  4000
`define ADC_MAX_RATE_MSPS    65
// least sample period allowed by the partner, rounded up to whole ticks
`define ADC_MIN_SAMPLE_TICKS ((1000000 / `ADC_MAX_RATE_MSPS + `ADC_CLOCK_PERIOD_PS - 1) / `ADC_CLOCK_PERIOD_PS)

`endif

// *** rtl/octal_adc_pkg.sv ***
`include "octal_adc_defines.svh"

package octal_adc_pkg;
	typedef logic [`ADC_WORD_BITS-1:0]                        word_t;
	typedef logic [`ADC_CHANNELS-1:0][`ADC_WORD_BITS-1:0]     lane_t;
endpackage : octal_adc_pkg

// *** rtl/two_entry_buffer.sv ***
`timescale 1ns/1ps

module two_entry_buffer #(
	parameter int WIDTH = 80
) (
	input  wire logic             clock,    // system clock
	input  wire logic             rst,      // sync reset, active high
	input  wire logic             inValid,  // producer has a word
	output logic                  inReady,  // buffer can take a word
	input  wire logic [WIDTH-1:0] inData,   // producer word
	output logic                  outValid, // output word valid
	input  wire logic             outReady, // consumer takes the word
	output logic [WIDTH-1:0]      outData   // output word, registered
);
	logic             skidValid;
	logic [WIDTH-1:0] skidData;
	logic             next_outValid;
	logic [WIDTH-1:0] next_outData;
	logic             next_skidValid;
	logic [WIDTH-1:0] next_skidData;

	// ready only from a flop, so the producer sees no path from outReady
	assign inReady = !skidValid;

	// output slot refills from the skid slot first to keep order
	always_comb begin
		next_outValid  = outValid;
		next_outData   = outData;
		next_skidValid = skidValid;
		next_skidData  = skidData;
		if (!outValid || outReady) begin
			if (skidValid) begin
				next_outValid  = 1'b1;
				next_outData   = skidData;
				next_skidValid = 1'b0;
			end else begin
				next_outValid = inValid;
				if (inValid) begin
					next_outData = inData;
				end
			end
		end else if (inValid && !skidValid) begin
			next_skidValid = 1'b1;
			next_skidData  = inData;
		end
	end

	// both slots register together; reset empties them
	always_ff @(posedge clock) begin
		if (rst) begin
			outValid  <= 1'b0;
			outData   <= '0;
			skidValid <= 1'b0;
			skidData  <= '0;
		end else begin
			outValid  <= next_outValid;
			outData   <= next_outData;
			skidValid <= next_skidValid;
			skidData  <= next_skidData;
		end
	end
endmodule : two_entry_buffer

// *** rtl/octal_adc_output.sv ***
`timescale 1ns/1ps
`include "octal_adc_defines.svh"

module octal_adc_output (
	input  wire logic                  clock,       // tick clock, two ticks per sample
	input  wire logic                  rst,         // sync reset, active high
	input  wire octal_adc_pkg::word_t  sampleA,     // quantised input, channel a
	input  wire octal_adc_pkg::word_t  sampleB,     // quantised input, channel b
	input  wire octal_adc_pkg::word_t  sampleC,     // quantised input, channel c
	input  wire octal_adc_pkg::word_t  sampleD,     // quantised input, channel d
	input  wire octal_adc_pkg::word_t  sampleE,     // quantised input, channel e
	input  wire octal_adc_pkg::word_t  sampleF,     // quantised input, channel f
	input  wire octal_adc_pkg::word_t  sampleG,     // quantised input, channel g
	input  wire octal_adc_pkg::word_t  sampleH,     // quantised input, channel h
	input  wire logic                  outEnableN,  // low drives data lines
	input  wire logic                  wordReady,   // capture logic takes the words
	output logic                       wordValid,   // all eight words valid
	output logic                       sampleTick,  // high on ticks that sample
	output logic                       dataDrive,   // high while data lines driven
	output octal_adc_pkg::word_t       chanAOut,    // channel a word, bit0 lsb
	output octal_adc_pkg::word_t       chanBOut,    // channel b word
	output octal_adc_pkg::word_t       chanCOut,    // channel c word
	output octal_adc_pkg::word_t       chanDOut,    // channel d word
	output octal_adc_pkg::word_t       chanEOut,    // channel e word
	output octal_adc_pkg::word_t       chanFOut,    // channel f word
	output octal_adc_pkg::word_t       chanGOut,    // channel g word
	output octal_adc_pkg::word_t       chanHOut     // channel h word
);
	import octal_adc_pkg::*;

	// ten resolving stages, then the correction ticks ahead of the output latch
	localparam int DEPTH       = `ADC_STAGES + `ADC_CORR_TICKS;
	// the residue only has to reach the last resolving stage
	localparam int RESID_DEPTH = `ADC_STAGES - 1;

	logic                     phase;
	logic                     next_phase;
	logic [DEPTH-1:0]         stValid;
	logic [DEPTH-1:0]         next_stValid;
	lane_t                    stResid [RESID_DEPTH];
	lane_t                    next_stResid [RESID_DEPTH];
	logic [`ADC_CHANNELS-1:0] stDecide [`ADC_STAGES];
	lane_t                    stCode [DEPTH];
	lane_t                    next_stCode [DEPTH];
	lane_t                    sampleLane;
	lane_t                    outLane;
	logic                     advance;
	logic                     bufReady;
	logic                     bufValid;
	logic                     next_dataDrive;

	// one shared clock captures every channel on the same tick
	always_comb begin
		sampleLane[0] = sampleA;
		sampleLane[1] = sampleB;
		sampleLane[2] = sampleC;
		sampleLane[3] = sampleD;
		sampleLane[4] = sampleE;
		sampleLane[5] = sampleF;
		sampleLane[6] = sampleG;
		sampleLane[7] = sampleH;
	end

	// a full buffer freezes the pipe; samples are skipped, never overwritten
	assign advance = bufReady;

	// sample phase: every second tick is a sampling instant
	always_comb begin
		next_phase = !phase;
	end

	// phase leaves reset high, so the first edge after release samples
	always_ff @(posedge clock) begin
		if (rst) begin
			phase <= 1'b1;
		end else begin
			phase <= next_phase;
		end
	end

	// high in the tick whose closing edge samples, straight from the phase flop
	assign sampleTick = phase;

	// valid marks ride one stage per tick; a frozen pipe keeps every mark
	always_comb begin
		next_stValid = stValid;
		if (advance) begin
			next_stValid[0] = phase;
			for (int s = 1; s < DEPTH; s++) begin
				next_stValid[s] = stValid[s-1];
			end
		end
	end

	// valid chain register
	always_ff @(posedge clock) begin
		if (rst) begin
			stValid <= '0;
		end else begin
			stValid <= next_stValid;
		end
	end

	// residue follows the codes as far as the last resolving stage
	always_comb begin
		for (int s = 0; s < RESID_DEPTH; s++) begin
			next_stResid[s] = stResid[s];
		end
		if (advance) begin
			next_stResid[0] = sampleLane;
			for (int s = 1; s < RESID_DEPTH; s++) begin
				next_stResid[s] = stResid[s-1];
			end
			// drop each bit once settled, so no later stage can read it again
			for (int s = 0; s < RESID_DEPTH; s++) begin
				for (int c = 0; c < `ADC_CHANNELS; c++) begin
					next_stResid[s][c][`ADC_WORD_BITS-1-s] = 1'b0;
				end
			end
		end
	end

	// residue chain register
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int s = 0; s < RESID_DEPTH; s++) begin
				stResid[s] <= '0;
			end
		end else begin
			for (int s = 0; s < RESID_DEPTH; s++) begin
				stResid[s] <= next_stResid[s];
			end
		end
	end

	// one-bit decision of every stage for every channel: stage 0 from sampleLane, later stages from the residue of the stage before
	always_comb begin
		for (int c = 0; c < `ADC_CHANNELS; c++) begin
			stDecide[0][c] = sampleLane[c][`ADC_WORD_BITS-1];
		end
		for (int s = 1; s < `ADC_STAGES; s++) begin
			for (int c = 0; c < `ADC_CHANNELS; c++) begin
				stDecide[s][c] = stResid[s-1][c][`ADC_WORD_BITS-1-s];
			end
		end
	end

	// half-clock pipeline: stage i settles bit (9 - i) of each channel
	always_comb begin
		for (int s = 0; s < DEPTH; s++) begin
			next_stCode[s] = stCode[s];
		end
		if (advance) begin
			next_stCode[0] = '0;
			for (int c = 0; c < `ADC_CHANNELS; c++) begin
				next_stCode[0][c][`ADC_WORD_BITS-1] = stDecide[0][c];
			end
			// resolving stages add one bit each
			for (int s = 1; s < `ADC_STAGES; s++) begin
				next_stCode[s] = stCode[s-1];
				for (int c = 0; c < `ADC_CHANNELS; c++) begin
					next_stCode[s][c][`ADC_WORD_BITS-1-s] = stDecide[s][c];
				end
			end
			// correction keeps no redundancy, so the word only takes time here
			for (int s = `ADC_STAGES; s < DEPTH; s++) begin
				next_stCode[s] = stCode[s-1];
			end
		end
	end

	// code chain register
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int s = 0; s < DEPTH; s++) begin
				stCode[s] <= '0;
			end
		end else begin
			for (int s = 0; s < DEPTH; s++) begin
				stCode[s] <= next_stCode[s];
			end
		end
	end

	// last correction tick feeds the output latch inside the buffer
	two_entry_buffer #(
		.WIDTH (`ADC_CHANNELS * `ADC_WORD_BITS)
	) u_buffer (
		.clock    (clock),
		.rst      (rst),
		.inValid  (stValid[DEPTH-1]),
		.inReady  (bufReady),
		.inData   (stCode[DEPTH-1]),
		.outValid (bufValid),
		.outReady (wordReady),
		.outData  (outLane)
	);

	// one latch for all lanes, so every port changes on the same edge
	assign wordValid = bufValid;
	assign chanAOut  = outLane[0];
	assign chanBOut  = outLane[1];
	assign chanCOut  = outLane[2];
	assign chanDOut  = outLane[3];
	assign chanEOut  = outLane[4];
	assign chanFOut  = outLane[5];
	assign chanGOut  = outLane[6];
	assign chanHOut  = outLane[7];

	// shared active-low enable; registered so the driver comes from a flop
	always_comb begin
		next_dataDrive = !outEnableN;
	end

	// pin drive register; lines stay released through reset
	always_ff @(posedge clock) begin
		if (rst) begin
			dataDrive <= 1'b0;
		end else begin
			dataDrive <= next_dataDrive;
		end
	end
endmodule : octal_adc_output

// *** tb/octal_adc_output_properties.sv ***
`timescale 1ns/1ps

module octal_adc_output_properties (
	input wire logic                 clock,      // tick clock
	input wire logic                 rst,        // sync reset
	input wire octal_adc_pkg::word_t sampleA,    // channel a input
	input wire octal_adc_pkg::word_t sampleH,    // channel h input
	input wire logic                 outEnableN, // pin enable, low drives
	input wire logic                 wordReady,  // capture takes words
	input wire logic                 wordValid,  // words on offer
	input wire logic                 sampleTick, // sampling phase
	input wire logic                 dataDrive,  // pins driven
	input wire octal_adc_pkg::word_t chanAOut,   // channel a word
	input wire octal_adc_pkg::word_t chanHOut    // channel h word
);
	import octal_adc_pkg::*;
	logic [3:0] sinceRst;
	logic [3:0] next_sinceRst;
	// edges since release; saturates so it never wraps into the first-word window
	always_comb next_sinceRst = rst ? 4'h0 : sinceRst + {3'h0, sinceRst != 4'hf};
	always_ff @(posedge clock) sinceRst <= next_sinceRst;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_drive_follows_enable: assert property (!$past(rst) |-> dataDrive == !$past(outEnableN))
		else $error("pin drive does not follow enable");
	chk_tick_falls: assert property (sampleTick |=> !sampleTick)
		else $error("sampling phase held high");
	chk_tick_rises: assert property (!sampleTick |=> sampleTick)
		else $error("sampling phase held low");
	chk_no_early_word: assert property (sinceRst < 4'hd |-> !wordValid)
		else $error("word before pipeline latency");
	chk_first_word_a: assert property (sinceRst == 4'hd |-> wordValid && chanAOut == $past(sampleA, 13))
		else $error("first channel a word wrong or late");
	chk_first_word_h: assert property (sinceRst == 4'hd |-> chanHOut == $past(sampleH, 13))
		else $error("first channel h word wrong or late");
	chk_stall_holds: assert property (wordValid && !wordReady |=> wordValid && $stable(chanAOut) && $stable(chanHOut))
		else $error("words changed while stalled");
	chk_change_handover: assert property (!$past(rst) && $changed(chanAOut) |-> !$past(wordValid) || $past(wordReady))
		else $error("word changed without handover");
endmodule : octal_adc_output_properties

bind octal_adc_output octal_adc_output_properties chk_u (.clock(clock), .rst(rst),
	.sampleA(sampleA), .sampleH(sampleH), .outEnableN(outEnableN), .wordReady(wordReady),
	.wordValid(wordValid), .sampleTick(sampleTick), .dataDrive(dataDrive),
	.chanAOut(chanAOut), .chanHOut(chanHOut));

// *** tb/capture_model.sv ***
`timescale 1ns/1ps

module capture_model (
	input wire logic clock,    // tick clock
	input wire logic slow,     // stall at random
	output logic     wordReady // takes the words
);
	integer seed = 32'h9ff66c1b;
	initial wordReady = 1'b1;
	// mostly low when slow, so the two-entry buffer fills and refuses
	always @(posedge clock) #1 wordReady <= slow ? (($random(seed) & 3) == 0) : 1'b1;
endmodule : capture_model

// *** tb/octal_adc_output_tb.sv ***
`timescale 1ns/1ps

module octal_adc_output_tb;
	import octal_adc_pkg::*;
	logic   clock = 1'b0;
	logic   rst = 1'b1;
	logic   outEnableN = 1'b0;
	logic   slow = 1'b0;
	logic   skipOk = 1'b0;
	logic   ph = 1'b0;
	logic   wordReady, wordValid, sampleTick, dataDrive;
	word_t  smp [8];
	word_t  chanOut [8];
	lane_t  cur, got;
	lane_t  q [$];
	integer seed = 32'h9ff66c1b;
	int     bad_count = 0;
	int     tests_run = 0;
	int     cyc = 0;
	// scaled time: a real clock source slows the tick to keep the sample rate in bounds
	always #2 clock = ~clock;
	octal_adc_output dut_u (.clock(clock), .rst(rst), .sampleA(smp[0]), .sampleB(smp[1]),
		.sampleC(smp[2]), .sampleD(smp[3]), .sampleE(smp[4]), .sampleF(smp[5]),
		.sampleG(smp[6]), .sampleH(smp[7]), .outEnableN(outEnableN), .wordReady(wordReady),
		.wordValid(wordValid), .sampleTick(sampleTick), .dataDrive(dataDrive),
		.chanAOut(chanOut[0]), .chanBOut(chanOut[1]), .chanCOut(chanOut[2]),
		.chanDOut(chanOut[3]), .chanEOut(chanOut[4]), .chanFOut(chanOut[5]),
		.chanGOut(chanOut[6]), .chanHOut(chanOut[7]));
	capture_model partner_u (.clock(clock), .slow(slow), .wordReady(wordReady));
	task check(input logic [79:0] seen, input logic [79:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// one random set for all channels, queued as the expected word
	task newSamples;
		for (int i = 0; i < 8; i++) begin
			smp[i] = word_t'($random(seed));
			cur[i] = smp[i];
		end
		q.push_back(cur);
	endtask : newSamples
	task doReset(input int n);
		rst = 1'b1;
		repeat (n) @(posedge clock);
		#1 rst = 1'b0;
		q.delete();
		skipOk = 1'b0;
		ph = 1'b0;
		newSamples();
	endtask : doReset
	// new samples every second tick, held across the sampling edge
	task run(input logic s, input logic oe, input int n, input int id);
		slow = s;
		outEnableN = oe;
		skipOk = skipOk | s;
		repeat (n) begin
			@(posedge clock);
			#1 ph = ~ph;
			if (ph) newSamples();
		end
		check(dataDrive, !oe);
		$display("test %0d done", id);
	endtask : run
	// a full buffer skips samples, so a stalled run may jump ahead, never back
	always @(posedge clock) begin
		if (!rst && wordValid === 1'b1 && wordReady === 1'b1) begin
			for (int i = 0; i < 8; i++) got[i] = chanOut[i];
			while (skipOk && q.size() > 1 && q[0] !== got) void'(q.pop_front());
			check(q.size() != 0, 1'b1);
			if (q.size() != 0) check(got, q.pop_front());
		end
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		newSamples();
		doReset(10);
		run(1'b0, 1'b0, 200, 1);
		run(1'b0, 1'b1, 40, 2);
		doReset(2);
		run(1'b0, 1'b0, 60, 3);
		run(1'b1, 1'b0, 400, 4);
		run(1'b0, 1'b0, 60, 5);
		tally_and_finish();
	end
endmodule : octal_adc_output_tb
